/* src/tx_status_pkg.sv */
// Package: register map, field positions and timing constants
package tx_status_pkg;

   // ==========================================================
   // Register indices (printed offsets are not word multiples)
   localparam logic [9:0] IDX_TEST_SUPPRESS = 10'h18B;
   localparam logic [9:0] IDX_HDLC256_SUPPRESS = 10'h18D;
   localparam logic [9:0] IDX_SYNC_CTRL = 10'h18E;
   localparam logic [9:0] IDX_STATUS_GENERAL = 10'h190;
   localparam logic [9:0] IDX_STATUS_HDLC64 = 10'h191;
   localparam logic [9:0] IDX_STATUS_SYNC = 10'h192;
   localparam logic [9:0] IDX_INT_INFO = 10'h19F;
   localparam logic [9:0] IDX_MASK_GENERAL = 10'h1A0;
   localparam logic [9:0] IDX_MASK_HDLC64 = 10'h1A1;
   localparam logic [9:0] IDX_MASK_SYNC = 10'h1A2;
   localparam logic [9:0] IDX_FIFO_CTRL = 10'h187;
   localparam logic [9:0] IDX_MODE = 10'h1C0;

   localparam logic [7:0] RESET_VALUE = 8'h00;

   // ==========================================================
   // Synchronizer control fields
   localparam int SYNC_MULTIFRAME_CHECK_SEARCH_EN_BIT = 3;
   localparam int SYNC_EN_BIT = 2;
   localparam int SYNC_NORESYNC_BIT = 1;
   localparam int SYNC_RESYNC_BIT = 0;

   // Mode register fields
   localparam int MODE_E1_BIT = 0;
   localparam int MODE_ESF_BIT = 1;
   localparam int MODE_SLC_BIT = 2;
   localparam int MODE_CLKOUT_BIT = 3;

   // Low watermark thresholds in bytes
   localparam logic [6:0] WM_CODE0 = 7'h04;
   localparam logic [6:0] WM_CODE1 = 7'h10;
   localparam logic [6:0] WM_CODE2 = 7'h20;
   localparam logic [6:0] WM_CODE3 = 7'h30;
   localparam logic [6:0] FIFO_BYTES = 7'h40;

   // ==========================================================
   // Timing: frame 125 us, line clock loss after 3 periods
   localparam int CLK_NS = 10;
   localparam int FRAME_US = 125;
   localparam int ALIGN_US = 250;
   localparam int ALIGN_FRAMES = ALIGN_US / FRAME_US;
   localparam int D4_FRAMES = 12;
   localparam int ESF_FRAMES = 24;
   localparam int E1_MF_FRAMES = 16;
   localparam int SLC_FRAMES = 72;
   localparam int LOSS_PERIODS = 3;
   localparam int FRAME_CYCLES = FRAME_US * 1000 / CLK_NS;

   // Events from the surrounding engines
   typedef struct packed {
      logic es_full;
      logic es_empty;
      logic link_reg_empty;
      logic fifo_underrun;
      logic message_end;
      logic sync_searching;
   } tx_events_t;

   typedef struct packed {
      logic [6:0] fifo_level;
      logic fifo_full;
   } fifo_state_t;

endpackage

/* src/tx_port_status_and_sync_regs.sv */
// Transmit suppress masks, synchronizer control and latched status
// Notes on behaviour
// (R1) Test-pattern suppress mask: a one removes that channel bit.
// (R2) HDLC-256 suppress mask; in E1 spare-bit use bits 4..0 mask Sa4..Sa8.
// (R3) E1 only: control bit 3 enables CRC-4 multiframe word search.
// (R4) Control bit 2 enables the transmit synchronizer.
// (R5) Control bit 1 set stops automatic resync after frame loss.
// (R6) Resync starts only on a rising edge of control bit 0.
// (R7) First status register bits are sticky and may interrupt.
// (R8) Elastic store full, empty and slip flags latch on events.
// (R9) T1, when enabled: bit 4 latches every 72-frame multiframe.
// (R10) E1: bit 3 latches every 250 us.
// (R11) Bit 2 latches at 1.5 ms D4, 3 ms ESF, 2 ms E1.
// (R12) Bit 1 latches when line clock transitions return.
// (R13) Bit 0 latches after about 3 silent periods; loss pin high.
// (R14) Loss status clearable while loss persists; pin follows condition.
// (R15) Unmasked set status pulls interrupt low until all cleared.
// (R16) T1: second-status bit 4 latches when link register empties.
// (R17) Bit 3 latches on FIFO underrun before message end.
// (R18) Bit 2 latches when an HDLC-64 message finishes.
// (R19) Bit 1 latches on rising edge of below-watermark condition.
// (R20) Bit 0 latches on rising edge of FIFO not-full.
// (R21) Sync status: bit 1 live searching, bit 0 latches search start.
// (R22) Info register bits 2..0 show which status register interrupts.
// (R23) Watermark select codes give 4, 16, 32, 48 bytes.
// (R24) Each latched bit has a mask; one lets it interrupt.
// (R25) Writing one clears a latched bit; a new event sets it.
// (R26) Every register resets to zero.
//
// Decided for this implementation: the APB register port.
module tx_port_status_and_sync_regs
   import tx_status_pkg::*;
#(
   parameter int LOSS_CYCLES = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transmit engines
   input wire logic tx_line_clock_in,
   input wire tx_events_t events,
   input wire fifo_state_t fifo,
   // Controls to engines
   output logic [7:0] test_port_suppress,
   output logic [7:0] hdlc256_suppress,
   output logic multiframe_check_search_en,
   output logic tx_synchronizer_en,
   output logic auto_resync_disable,
   output logic resync_start,
   output logic [6:0] low_watermark_level,
   // Alarms
   output logic clock_loss_out,
   output logic interrupt_out_n
);

   // Loss counter is 8 bits and needs at least two quiet cycles
   if (LOSS_CYCLES < 2 || LOSS_CYCLES > 255) begin : g_loss_range
      $error("LOSS_CYCLES out of range");
   end

   // ==========================================================
   // APB decode
   logic setup;
   logic wr;
   logic [9:0] idx;
   logic wr_en;

   // Byte lane 0 carries every register; other lanes are ignored
   assign idx = paddr[11:2];
   // Zero wait states: pready is the setup phase, registered
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pstrb[0];
   assign wr = wr_en;

   // Control registers
   logic [7:0] test_sup_q;
   logic [7:0] hdlc_sup_q;
   logic [3:0] sync_ctrl_q;
   logic [1:0] wm_sel_q;
   logic [3:0] mode_q;
   // Masks narrower than a byte read back zero-padded
   logic [7:0] mask1_q;
   logic [4:0] mask2_q;
   logic mask3_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_sup_q <= RESET_VALUE; // [R26]
         hdlc_sup_q <= RESET_VALUE;
         sync_ctrl_q <= 4'h0;
         wm_sel_q <= 2'h0;
         mode_q <= 4'h0;
         mask1_q <= RESET_VALUE;
         mask2_q <= 5'h00;
         mask3_q <= 1'b0;
      end else if (wr) begin
         case (idx)
            IDX_TEST_SUPPRESS: test_sup_q <= pwdata[7:0]; // [R1]
            IDX_HDLC256_SUPPRESS: hdlc_sup_q <= pwdata[7:0]; // [R2]
            IDX_SYNC_CTRL: sync_ctrl_q <= pwdata[3:0];
            IDX_FIFO_CTRL: wm_sel_q <= pwdata[1:0];
            IDX_MODE: mode_q <= pwdata[3:0];
            IDX_MASK_GENERAL: mask1_q <= pwdata[7:0]; // [R24]
            IDX_MASK_HDLC64: mask2_q <= pwdata[4:0];
            IDX_MASK_SYNC: mask3_q <= pwdata[0];
            // Status and info words are not plain registers
            default: ;
         endcase
      end
   end

   // T1 is the line mode after reset
   logic e1;
   assign e1 = mode_q[MODE_E1_BIT];

   // ==========================================================
   // Control outputs
   // Last written resync bit, so a held one starts nothing new
   logic resync_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_port_suppress <= RESET_VALUE;
         hdlc256_suppress <= RESET_VALUE;
         multiframe_check_search_en <= 1'b0;
         tx_synchronizer_en <= 1'b0;
         auto_resync_disable <= 1'b0;
         resync_start <= 1'b0;
         resync_prev_q <= 1'b0;
         low_watermark_level <= WM_CODE0;
      end else begin
         test_port_suppress <= test_sup_q; // [R1]
         // Spare-bit mapping is the same field layout [R2]
         hdlc256_suppress <= hdlc_sup_q;
         multiframe_check_search_en <=
            e1 & sync_ctrl_q[SYNC_MULTIFRAME_CHECK_SEARCH_EN_BIT]; // [R3]
         tx_synchronizer_en <= sync_ctrl_q[SYNC_EN_BIT]; // [R4]
         auto_resync_disable <= sync_ctrl_q[SYNC_NORESYNC_BIT]; // [R5]
         resync_prev_q <= sync_ctrl_q[SYNC_RESYNC_BIT];
         resync_start <= sync_ctrl_q[SYNC_RESYNC_BIT]
            & ~resync_prev_q; // [R6]
         // Decoded once here, so the FIFO compare is a plain less-than
         case (wm_sel_q) // [R23]
            2'h0: low_watermark_level <= WM_CODE0;
            2'h1: low_watermark_level <= WM_CODE1;
            2'h2: low_watermark_level <= WM_CODE2;
            default: low_watermark_level <= WM_CODE3;
         endcase
      end
   end

   // ==========================================================
   // Line clock loss: count cycles with no transition
   // Limitation: the line clock must toggle within LOSS_CYCLES
   logic line_prev_q;
   logic [7:0] silent_q;
   logic loss_q;
   logic loss_set;
   logic loss_clr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_prev_q <= 1'b0;
         silent_q <= 8'h00;
         loss_q <= 1'b0;
      end else begin
         line_prev_q <= tx_line_clock_in;
         if (tx_line_clock_in != line_prev_q) begin
            silent_q <= 8'h00;
            loss_q <= 1'b0;
         end else if (silent_q != 8'(LOSS_CYCLES)) begin
            silent_q <= silent_q + 8'h01;
         end else begin
            loss_q <= 1'b1; // [R13]
         end
      end
   end
   // Set and clear strobes for the status latches, one cycle each
   assign loss_set = ~loss_q & (silent_q == 8'(LOSS_CYCLES))
      & (tx_line_clock_in == line_prev_q);
   assign loss_clr = loss_q & (tx_line_clock_in != line_prev_q);

   // Pin follows condition, not the status bit
   // Mode bit 3 gates the pin only; the status bit is never gated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_loss_out <= 1'b0;
      end else begin
         clock_loss_out <= mode_q[MODE_CLKOUT_BIT]
            & (loss_q | loss_set) & ~loss_clr; // [R14]
      end
   end

   // ==========================================================
   // Frame timing from a 125 us tick
   // Free-running: its phase is not tied to the engine's frames
   logic [13:0] frame_cnt_q;
   logic frame_tick;
   logic [6:0] mf_cnt_q;
   logic [6:0] slc_cnt_q;
   logic [6:0] mf_len;

   assign frame_tick = frame_cnt_q == 14'(FRAME_CYCLES - 1);

   always_comb begin
      // E1 keeps 16 frames whether or not CRC-4 is searched
      if (e1) begin
         mf_len = 7'(E1_MF_FRAMES);
      end else if (mode_q[MODE_ESF_BIT]) begin
         mf_len = 7'(ESF_FRAMES);
      end else begin
         mf_len = 7'(D4_FRAMES);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_cnt_q <= 14'h0000;
         mf_cnt_q <= 7'h00;
         slc_cnt_q <= 7'h00;
      end else begin
         frame_cnt_q <= frame_tick ? 14'h0000 : frame_cnt_q + 14'h0001;
         if (frame_tick) begin
            mf_cnt_q <= (mf_cnt_q >= mf_len - 7'h01) ? 7'h00
               : mf_cnt_q + 7'h01;
            slc_cnt_q <= (slc_cnt_q == 7'(SLC_FRAMES - 1)) ? 7'h00
               : slc_cnt_q + 7'h01;
         end
      end
   end

   // One-cycle event strobes into the first status register
   logic mf_ev;
   logic align_ev;
   logic slc_ev;
   assign mf_ev = frame_tick & (mf_cnt_q >= mf_len - 7'h01); // [R11]
   // Two frames make 250 us
   assign align_ev = e1 & frame_tick
      & (mf_cnt_q[0] == 1'(ALIGN_FRAMES - 1)); // [R10]
   // Long multiframe only in T1 with its enable bit set
   assign slc_ev = ~e1 & mode_q[MODE_SLC_BIT] & frame_tick
      & (slc_cnt_q == 7'(SLC_FRAMES - 1)); // [R9]

   // ==========================================================
   // FIFO edge detection
   logic below_now;
   logic not_full_now;
   logic below_prev_q;
   logic not_full_prev_q;
   logic search_prev_q;

   // Below watermark: fewer bytes held than the selected level
   assign below_now = fifo.fifo_level < low_watermark_level; // [R19]
   assign not_full_now = ~fifo.fifo_full;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Idle levels of an empty FIFO: no false edge after reset
         below_prev_q <= 1'b1;
         not_full_prev_q <= 1'b1;
         search_prev_q <= 1'b0;
      end else begin
         below_prev_q <= below_now;
         not_full_prev_q <= not_full_now;
         search_prev_q <= events.sync_searching;
      end
   end

   // ==========================================================
   // Latched status, write one to clear, set wins
   logic [7:0] set1;
   logic [4:0] set2;
   logic set3;
   logic [7:0] st1_q;
   logic [4:0] st2_q;
   logic st3_q;
   logic [7:0] clr;

   assign set1 = {events.es_full, events.es_empty, // [R8]
      events.es_full | events.es_empty, slc_ev, align_ev, mf_ev,
      loss_clr, loss_set}; // [R12] [R13]
   // HDLC-64 group; the link register flag exists only in T1
   assign set2 = {~e1 & events.link_reg_empty, // [R16]
      events.fifo_underrun, // [R17]
      events.message_end, // [R18]
      below_now & ~below_prev_q, // [R19]
      not_full_now & ~not_full_prev_q}; // [R20]
   // Latched on the start of a search; the live bit is read directly
   assign set3 = events.sync_searching & ~search_prev_q; // [R21]
   // Write-one-to-clear: a zero bit in the write leaves its latch
   assign clr = pwdata[7:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st1_q <= RESET_VALUE;
         st2_q <= 5'h00;
         st3_q <= 1'b0;
      end else begin
         // Set wins over a clear in the same cycle [R25] [R7]
         st1_q <= (st1_q & ~((wr && idx == IDX_STATUS_GENERAL)
            ? clr : 8'h00)) | set1; // [R14]
         st2_q <= (st2_q & ~((wr && idx == IDX_STATUS_HDLC64)
            ? clr[4:0] : 5'h00)) | set2;
         st3_q <= (st3_q & ~(wr && idx == IDX_STATUS_SYNC && clr[0]))
            | set3;
      end
   end

   // ==========================================================
   // Interrupt summary
   logic [2:0] pend;
   // Real-time summary, one bit for each status register
   assign pend = {st3_q & mask3_q, |(st2_q & mask2_q),
      |(st1_q & mask1_q)}; // [R22] [R24]

   // Registered, so the pin follows its status bit one cycle late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= ~(|pend); // [R15]
      end
   end

   // ==========================================================
   // Read data, registered in setup; zero-wait answer
   logic [7:0] rd;
   logic hit;

   // Unmapped index answers with an error and reads as zero
   always_comb begin
      hit = 1'b1;
      case (idx)
         IDX_TEST_SUPPRESS: rd = test_sup_q;
         IDX_HDLC256_SUPPRESS: rd = hdlc_sup_q;
         IDX_SYNC_CTRL: rd = {4'h0, sync_ctrl_q};
         IDX_FIFO_CTRL: rd = {6'h00, wm_sel_q};
         IDX_MODE: rd = {4'h0, mode_q};
         IDX_STATUS_GENERAL: rd = st1_q;
         IDX_STATUS_HDLC64: rd = {3'h0, st2_q};
         IDX_STATUS_SYNC: rd = {6'h00, events.sync_searching, st3_q};
         IDX_INT_INFO: rd = {5'h00, pend}; // [R22]
         IDX_MASK_GENERAL: rd = mask1_q;
         IDX_MASK_HDLC64: rd = {3'h0, mask2_q};
         IDX_MASK_SYNC: rd = {7'h00, mask3_q};
         default: begin
            rd = 8'h00;
            hit = 1'b0;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         // Read data stands until the next read
         if (setup && !pwrite) begin
            prdata <= {24'h000000, rd};
         end
      end
   end

endmodule

/* tb/tx_status_asserts.sv */
// Checker: port-level properties of the transmit status register block
module tx_status_asserts
   import tx_status_pkg::*;
#(
   parameter int LOSS_CYCLES = 8
) (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Engine side
   input wire logic tx_line_clock_in,
   input wire tx_events_t events,
   input wire fifo_state_t fifo,
   input wire logic [7:0] test_port_suppress,
   input wire logic [7:0] hdlc256_suppress,
   input wire logic multiframe_check_search_en,
   input wire logic tx_synchronizer_en,
   input wire logic auto_resync_disable,
   input wire logic resync_start,
   input wire logic [6:0] low_watermark_level,
   input wire logic clock_loss_out,
   input wire logic interrupt_out_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slack for where the block starts its own quiet count
   localparam int QMIN = LOSS_CYCLES - 2;
   logic acc, mapped, wr_resync, wr_supp, line_q;
   logic [8:0] quiet_q;
   assign acc = psel && penable;
   assign mapped = paddr[11:2] inside {IDX_TEST_SUPPRESS,
      IDX_HDLC256_SUPPRESS, IDX_SYNC_CTRL, IDX_STATUS_GENERAL,
      IDX_STATUS_HDLC64, IDX_STATUS_SYNC, IDX_INT_INFO, IDX_MASK_GENERAL,
      IDX_MASK_HDLC64, IDX_MASK_SYNC, IDX_FIFO_CTRL, IDX_MODE};
   assign wr_resync = acc && pwrite && pstrb[0] && pwdata[0]
      && paddr[11:2] == IDX_SYNC_CTRL;
   assign wr_supp = acc && pwrite && pstrb[0]
      && paddr[11:2] == IDX_TEST_SUPPRESS;
   // =========================================================
   // Cycles since the line clock last moved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q <= 1'b0;
         quiet_q <= 9'h000;
      end else begin
         line_q <= tx_line_clock_in;
         if (line_q != tx_line_clock_in) quiet_q <= 9'h000;
         else if (quiet_q != 9'h1FF) quiet_q <= quiet_q + 9'h001;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =========================================================
   // Properties
   ready_in_access_a: assert property (acc |-> pready)
      else $error("pready low in access phase");
   error_when_unmapped_a: assert property (acc |-> pslverr == !mapped)
      else $error("pslverr does not follow address map");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   refused_reads_zero_a: assert property (pslverr && !pwrite |->
      prdata == 32'h0000_0000) else $error("refused read not zero");
   upper_bits_zero_a: assert property (pready && !pwrite |->
      prdata[31:8] == 24'h00_0000) else $error("read upper bits set");
   resync_single_a: assert property (
      resync_start |=> !resync_start [*3])
      else $error("resync pulse too long or too close");
   resync_cause_a: assert property (
      $rose(resync_start) |-> $past(wr_resync, 2) || $past(wr_resync, 3))
      else $error("resync without write of a one");
   suppress_follows_a: assert property (
      $changed(test_port_suppress) |-> $past(wr_supp) || $past(wr_supp, 2))
      else $error("suppress mask changed without write");
   watermark_legal_a: assert property (
      low_watermark_level inside {7'h04, 7'h10, 7'h20, 7'h30})
      else $error("watermark level not a legal threshold");
   loss_after_quiet_a: assert property (
      $rose(clock_loss_out) |-> int'(quiet_q) >= QMIN)
      else $error("clock loss raised too early");
   loss_ends_a: assert property (
      $changed(tx_line_clock_in) |-> ##[1:4] !clock_loss_out)
      else $error("clock loss pin stuck after clock returned");
endmodule

bind tx_port_status_and_sync_regs tx_status_asserts #(
   .LOSS_CYCLES(LOSS_CYCLES)
) i_tx_status_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_line_clock_in, .events,
   .fifo, .test_port_suppress, .hdlc256_suppress,
   .multiframe_check_search_en, .tx_synchronizer_en, .auto_resync_disable,
   .resync_start, .low_watermark_level, .clock_loss_out, .interrupt_out_n);

/* tb/testbench.sv */
// Testbench: register table, status latches, resync and clock loss
module testbench;
   import tx_status_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [9:0] idx;
      logic [7:0] wd;
      logic [31:0] exp;
      logic err;
   } row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_run;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   tx_events_t events;
   fifo_state_t fifo;
   logic tx_line_clock_in, multiframe_check_search_en, tx_synchronizer_en;
   logic auto_resync_disable, resync_start, clock_loss_out, interrupt_out_n;
   logic [7:0] test_port_suppress, hdlc256_suppress;
   logic [6:0] low_watermark_level;
   int err_count, checks, cyc, pulses;
   logic [31:0] wm [4] = '{32'h4, 32'h10, 32'h20, 32'h30};
   logic [9:0] zidx [9] = '{IDX_TEST_SUPPRESS, IDX_HDLC256_SUPPRESS,
      IDX_SYNC_CTRL, IDX_STATUS_GENERAL, IDX_STATUS_HDLC64, IDX_STATUS_SYNC,
      IDX_INT_INFO, IDX_MASK_GENERAL, IDX_MODE};
   // Register index, write value, read back, expected refusal
   row_t rows [10] = '{'{IDX_TEST_SUPPRESS, 8'hA5, 32'hA5, 1'b0},
      '{IDX_HDLC256_SUPPRESS, 8'h5A, 32'h5A, 1'b0},
      '{IDX_SYNC_CTRL, 8'h0E, 32'h0E, 1'b0},
      '{IDX_FIFO_CTRL, 8'h03, 32'h03, 1'b0},
      '{IDX_MASK_GENERAL, 8'hFF, 32'hFF, 1'b0},
      '{IDX_MASK_HDLC64, 8'h1F, 32'h1F, 1'b0},
      '{IDX_MASK_SYNC, 8'h01, 32'h01, 1'b0},
      '{IDX_MODE, 8'h08, 32'h08, 1'b0},
      '{10'h1FF, 8'h77, 32'h0, 1'b1},
      '{IDX_INT_INFO, 8'h07, 32'h0, 1'b0}};

   tx_port_status_and_sync_regs #(
      .LOSS_CYCLES(8)
   ) i_tx_port_status_and_sync_regs (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .tx_line_clock_in, .events, .fifo,
      .test_port_suppress, .hdlc256_suppress, .multiframe_check_search_en,
      .tx_synchronizer_en, .auto_resync_disable, .resync_start,
      .low_watermark_level, .clock_loss_out, .interrupt_out_n);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (line_run) tx_line_clock_in <= ~tx_line_clock_in;
      if (resync_start === 1'b1) pulses++;
      cyc++;
      if (cyc == 50000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run;
      if (err_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for pready, samples at that edge
   task automatic apb(input logic [9:0] idx, input logic w,
      input logic [7:0] wd, output logic [31:0] rd, output logic er);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
      logic [31:0] x;
      logic e;
      apb(idx, 1'b1, wd, x, e);
   endtask
   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp,
      input logic [31:0] m);
      logic [31:0] x;
      logic e;
      apb(idx, 1'b0, 8'h00, x, e);
      chk(x & m, exp);
   endtask
   task automatic pulse(input tx_events_t e);
      @(posedge pclk);
      events <= e;
      @(posedge pclk);
      events <= '0;
   endtask
   task automatic clr_all;
      wr(IDX_STATUS_GENERAL, 8'hFF);
      wr(IDX_STATUS_HDLC64, 8'hFF);
      wr(IDX_STATUS_SYNC, 8'hFF);
   endtask
   task automatic settle;
      repeat (2) @(negedge pclk);
   endtask

   initial begin
      logic [31:0] x;
      logic e;
      int k;
      {presetn, psel, penable, pwrite, tx_line_clock_in} = 5'h00;
      {paddr, pwdata, pstrb, events} = '0;
      pstrb = 4'hF;
      fifo = {7'h40, 1'b1};
      line_run = 1'b1;
      {err_count, checks, cyc, pulses} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (zidx[k]) rdc(zidx[k], 32'h0, 32'hFF);
      settle();
      chk({interrupt_out_n, test_port_suppress, tx_synchronizer_en},
         32'h200);
      foreach (rows[k]) begin
         wr(rows[k].idx, rows[k].wd);
         apb(rows[k].idx, 1'b0, 8'h00, x, e);
         chk(x, rows[k].exp);
         chk({31'h0, e}, {31'h0, rows[k].err});
      end
      settle();
      chk({test_port_suppress, hdlc256_suppress, multiframe_check_search_en,
         tx_synchronizer_en, auto_resync_disable},
         32'h52AD3);
      for (k = 0; k < 4; k++) begin
         wr(IDX_FIFO_CTRL, 8'(k));
         settle();
         chk({25'h0, low_watermark_level}, wm[k]);
      end
      // Elastic store slips; clear the full bit alone, then all
      clr_all();
      pulse(6'h20);
      rdc(IDX_STATUS_GENERAL, 32'hA0, 32'hE0);
      rdc(IDX_INT_INFO, 32'h1, 32'h7);
      chk({31'h0, interrupt_out_n}, 32'h0);
      wr(IDX_STATUS_GENERAL, 8'h80);
      pulse(6'h10);
      rdc(IDX_STATUS_GENERAL, 32'h60, 32'hE0);
      clr_all();
      rdc(IDX_INT_INFO, 32'h0, 32'h7);
      chk({31'h0, interrupt_out_n}, 32'h1);
      // Masked event keeps the output high until unmasked
      wr(IDX_MASK_GENERAL, 8'h00);
      pulse(6'h20);
      rdc(IDX_INT_INFO, 32'h0, 32'h7);
      chk({31'h0, interrupt_out_n}, 32'h1);
      wr(IDX_MASK_GENERAL, 8'hFF);
      settle();
      chk({31'h0, interrupt_out_n}, 32'h0);
      clr_all();
      // Second status group with a full fifo draining
      pulse(6'h0E);
      rdc(IDX_STATUS_HDLC64, 32'h1C, 32'h1C);
      wr(IDX_STATUS_HDLC64, 8'hFF);
      @(posedge pclk);
      fifo <= {7'h3F, 1'b0};
      rdc(IDX_STATUS_HDLC64, 32'h1, 32'h3);
      rdc(IDX_INT_INFO, 32'h2, 32'h7);
      @(posedge pclk);
      fifo <= {7'h28, 1'b0};
      rdc(IDX_STATUS_HDLC64, 32'h3, 32'h3);
      @(posedge pclk);
      events <= 6'h01;
      rdc(IDX_STATUS_SYNC, 32'h3, 32'h3);
      rdc(IDX_INT_INFO, 32'h6, 32'h7);
      @(posedge pclk);
      events <= '0;
      clr_all();
      rdc(IDX_STATUS_SYNC, 32'h0, 32'h3);
      // Repeated one, then a fresh rising edge
      wr(IDX_SYNC_CTRL, 8'h0F);
      wr(IDX_SYNC_CTRL, 8'h0F);
      wr(IDX_SYNC_CTRL, 8'h0E);
      wr(IDX_SYNC_CTRL, 8'h0F);
      repeat (4) @(posedge pclk);
      chk(pulses, 32'h2);
      // Line clock stops, status cleared while loss lasts
      @(posedge pclk);
      line_run <= 1'b0;
      repeat (20) @(posedge pclk);
      rdc(IDX_STATUS_GENERAL, 32'h1, 32'h3);
      wr(IDX_STATUS_GENERAL, 8'h01);
      rdc(IDX_STATUS_GENERAL, 32'h0, 32'h1);
      chk({31'h0, clock_loss_out}, 32'h1);
      @(posedge pclk);
      line_run <= 1'b1;
      repeat (6) @(posedge pclk);
      rdc(IDX_STATUS_GENERAL, 32'h2, 32'h3);
      chk({31'h0, clock_loss_out}, 32'h0);
      // E1 mode: search enable and align ticks every 2 frames
      wr(IDX_MODE, 8'h09);
      clr_all();
      chk({31'h0, multiframe_check_search_en}, 32'h1);
      k = 0;
      do begin
         apb(IDX_STATUS_GENERAL, 1'b0, 8'h00, x, e);
         k++;
      end while (x[3] !== 1'b1 && k < 10000);
      chk(x & 32'h8, 32'h8);
      pulse(6'h08);
      rdc(IDX_STATUS_HDLC64, 32'h0, 32'h10);
      // Reset again in mid-run: nine listed registers back to zero
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (zidx[k]) rdc(zidx[k], 32'h0, 32'hFF);
      chk({interrupt_out_n, clock_loss_out, low_watermark_level},
         32'h104);
      complete_run();
   end
endmodule
